/* design/fles_sequencer.sv */
// Purpose: lock, unlock, erase and sector-protect sequencer of an on-chip flash
// Assumes: register writes are single-cycle strobes synchronous to ref_clk
// Notes: the flash array is outside; this block drives its program/erase strobes
//
// Function
// - reset leaves controller locked; program and erase refused until unlocked
// - page select write, then 73H then 8CH advance unlock state
// - page select rewrite must match earlier value, else relock
// - 95H when unlocked starts page erase of a page in an unprotected main sector, or of info page 3
// - an out-of-sequence command write relocks the controller unless a program or erase is running
// - unlocked page accepts repeated byte writes; next command write relocks
// - 5EH routes next write at 02H to sector lock
// - sector lock bits reset zero, set once, stay set
// - sectors are 16 pages; small part 4 sectors, large 8
// - only the page held in the page selector is programmable; mass erase relocks on completion, clearing its all-bytes enable
// - programming only clears bits; erased byte reads FFH
// - cpu stalled while cpu-started program or erase runs; clock keeps running
// - page erase sets whole selected page to FFH
// - controller relocks after page or mass erase completes
// - port busy bit 3 held while port-started operation runs
// - 63H starts mass erase of main memory only
// - mass erase accepted only from the serial programming port
// - protected info page 3 erase needs mass erase this session
// - six-bit status code reports state, upper two bits zero
// - command and status share address 01H, status always readable
// - page selector bit 7 picks info area, low bits page
// - durations are fixed cycle counts, timing divisor ignored; about 55 us and 10 ms at 100 MHz
// - sector lock bit n protects sector n
module fles_sequencer #(
    parameter int SECTORS = 8,
    parameter int PROG_CYCLES = fles_pkg::PROG_CYCLES,
    parameter int ERASE_CYCLES = fles_pkg::ERASE_CYCLES,
    parameter int TWIDTH = 24
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire fles_pkg::fles_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire fles_pkg::fles_prog_req_t prog_req,
    input wire logic protect_option,
    input wire logic [15:0] timing_divisor,
    output logic cpu_stall,
    output logic port_busy,
    output logic [7:0] port_status,
    output logic flash_prog,
    output logic flash_page_erase,
    output logic flash_mass_erase,
    output logic flash_info,
    output logic [15:0] flash_addr,
    output logic [7:0] flash_wdata,
    output logic [7:0] sector_lock
);
    fles_pkg::fles_state_t state_reg;
    fles_pkg::fles_state_t state_next;
    logic [7:0] page_selector_reg;
    logic [7:0] first_page_reg;
    logic [7:0] sector_lock_reg;
    logic mass_enabled_reg;
    logic page_active_reg;
    logic port_op_reg;
    logic mass_done_session_reg;
    logic timer_start;
    logic [TWIDTH-1:0] timer_cycles;
    logic timer_busy;
    logic timer_done;
    logic cmd_wr;
    logic ps_wr;
    logic in_page;
    logic sector_open;

    // ********************************
    // helpers
    // ********************************
    function automatic logic [2:0] sector_of(input logic [6:0] page);
        sector_of = page[6:fles_pkg::PAGES_PER_SECTOR_LOG2];
    endfunction : sector_of

    function automatic logic sector_ok(input logic [7:0] locks, input logic [6:0] page);
        logic [2:0] s;
        s = sector_of(page);
        sector_ok = (32'(s) < SECTORS) ? !locks[s] : 1'b0;
    endfunction : sector_ok

    // divisor ignored: fixed counts, about 55 us and 10 ms at 100 MHz ref_clk
    function automatic logic [TWIDTH-1:0] scale(input int base, input logic [15:0] div);
        scale = (div == 16'h0000) ? TWIDTH'(base) : TWIDTH'(base);
    endfunction : scale

    assign cmd_wr = reg_req.wr && reg_req.addr == fles_pkg::ADDR_FLASH_COMMAND;
    assign ps_wr = reg_req.wr && reg_req.addr == fles_pkg::ADDR_PAGE_SELECTOR;
    // page mode restricts programming to the active page, mass mode opens all pages of unprotected sectors
    assign in_page = page_selector_reg[fles_pkg::INFO_AREA_BIT]
        ? (prog_req.info && prog_req.addr[7:6] == page_selector_reg[1:0])
        : (!prog_req.info && prog_req.addr[15:9] == page_selector_reg[6:0]);
    assign sector_open = prog_req.info || sector_ok(sector_lock_reg, prog_req.addr[15:9]);

    // ********************************
    // state machine
    // ********************************
    always_comb
    begin
        state_next = state_reg;
        timer_start = 1'b0;
        timer_cycles = scale(PROG_CYCLES, timing_divisor);
        unique case (state_reg)
            fles_pkg::ST_LOCKED:
                if (cmd_wr && reg_req.wdata == fles_pkg::CMD_KEY1)
                    state_next = fles_pkg::ST_KEY1;
            fles_pkg::ST_KEY1:
                if (cmd_wr)
                    state_next = (reg_req.wdata == fles_pkg::CMD_KEY2)
                        ? fles_pkg::ST_KEY2 : fles_pkg::ST_LOCKED;
                else if (ps_wr)
                    state_next = fles_pkg::ST_LOCKED;
            fles_pkg::ST_KEY2:
                if (ps_wr)
                    state_next = (reg_req.wdata == first_page_reg)
                        ? fles_pkg::ST_UNLOCKED : fles_pkg::ST_LOCKED;
                else if (cmd_wr)
                    state_next = fles_pkg::ST_LOCKED;
            fles_pkg::ST_UNLOCKED:
                if (cmd_wr)
                begin
                    state_next = fles_pkg::ST_LOCKED;
                    if (reg_req.wdata == fles_pkg::CMD_SECTOR_SEL)
                        state_next = fles_pkg::ST_SECTOR_SEL;
                    else if (reg_req.wdata == fles_pkg::CMD_PAGE_ERASE && page_active_reg)
                    begin
                        if (page_selector_reg[fles_pkg::INFO_AREA_BIT]
                            ? (page_selector_reg[6:0] == fles_pkg::INFO_USER_PAGE
                               && (!protect_option || mass_done_session_reg))
                            : sector_ok(sector_lock_reg, page_selector_reg[6:0]))
                        begin
                            state_next = fles_pkg::ST_PAGE_ERASE;
                            timer_start = 1'b1;
                            timer_cycles = scale(ERASE_CYCLES, timing_divisor);
                        end
                    end
                    else if (reg_req.wdata == fles_pkg::CMD_MASS_ERASE && reg_req.from_port)
                    begin
                        state_next = fles_pkg::ST_MASS_ERASE;
                        timer_start = 1'b1;
                        timer_cycles = scale(ERASE_CYCLES, timing_divisor);
                    end
                end
                else if (prog_req.wr && (in_page || mass_enabled_reg) && sector_open)
                begin
                    state_next = fles_pkg::ST_PROGRAM;
                    timer_start = 1'b1;
                end
            fles_pkg::ST_SECTOR_SEL:
                if (ps_wr)
                    state_next = fles_pkg::ST_UNLOCKED;
                else if (cmd_wr)
                    state_next = fles_pkg::ST_LOCKED;
            fles_pkg::ST_PROGRAM:
                if (timer_done)
                    state_next = fles_pkg::ST_UNLOCKED;
            fles_pkg::ST_PAGE_ERASE, fles_pkg::ST_MASS_ERASE:
                if (timer_done)
                    state_next = fles_pkg::ST_LOCKED;
            default:
                state_next = fles_pkg::ST_LOCKED;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            state_reg <= fles_pkg::ST_LOCKED;
        else if (clk_en)
            state_reg <= state_next;
    end

    // ********************************
    // page selector and unlock memory
    // ********************************
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            page_selector_reg <= fles_pkg::RST_PAGE_SELECTOR;
            first_page_reg <= fles_pkg::RST_PAGE_SELECTOR;
            page_active_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (ps_wr && state_reg != fles_pkg::ST_SECTOR_SEL)
                page_selector_reg <= reg_req.wdata;
            if (ps_wr && state_reg == fles_pkg::ST_LOCKED)
                first_page_reg <= reg_req.wdata;
            if (state_next == fles_pkg::ST_LOCKED)
                page_active_reg <= 1'b0;
            else if (state_reg == fles_pkg::ST_KEY2 && state_next == fles_pkg::ST_UNLOCKED)
                page_active_reg <= 1'b1;
        end
    end

    // write-once bits; only a power-down clears them, modelled by reset
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            sector_lock_reg <= fles_pkg::RST_SECTOR_LOCK;
        else if (clk_en && ps_wr && state_reg == fles_pkg::ST_SECTOR_SEL)
            sector_lock_reg <= sector_lock_reg | reg_req.wdata;
    end

    // mass mode stays open until relock; session flag gates info page 3
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mass_enabled_reg <= 1'b0;
            mass_done_session_reg <= 1'b0;
            port_op_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (state_reg == fles_pkg::ST_MASS_ERASE && timer_done)
                mass_done_session_reg <= 1'b1;
            if (state_next == fles_pkg::ST_LOCKED)
                mass_enabled_reg <= 1'b0;
            else if (state_next == fles_pkg::ST_MASS_ERASE)
                mass_enabled_reg <= 1'b1;
            if (timer_start)
                port_op_reg <= reg_req.from_port;
        end
    end

    fles_timer #(
        .WIDTH(TWIDTH)
    ) u_timer (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .start(timer_start),
        .cycles(timer_cycles),
        .busy(timer_busy),
        .done(timer_done)
    );

    // ********************************
    // flash array strobes and status
    // ********************************
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            flash_prog <= 1'b0;
            flash_page_erase <= 1'b0;
            flash_mass_erase <= 1'b0;
            flash_info <= 1'b0;
            flash_addr <= 16'h0000;
            flash_wdata <= fles_pkg::ERASED_BYTE;
        end
        else if (clk_en)
        begin
            flash_prog <= timer_start && state_next == fles_pkg::ST_PROGRAM;
            flash_page_erase <= timer_start && state_next == fles_pkg::ST_PAGE_ERASE;
            flash_mass_erase <= timer_start && state_next == fles_pkg::ST_MASS_ERASE;
            if (timer_start)
            begin
                // mass erase never reaches the info area
                flash_info <= (state_next == fles_pkg::ST_PROGRAM) ? prog_req.info
                    : page_selector_reg[fles_pkg::INFO_AREA_BIT]
                    && state_next == fles_pkg::ST_PAGE_ERASE;
                flash_addr <= (state_next == fles_pkg::ST_PROGRAM) ? prog_req.addr
                    : {page_selector_reg[6:0], 9'h000};
                flash_wdata <= prog_req.wdata;  // array ANDs this into the cell
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= fles_pkg::RST_FLASH_STATE;
        else if (clk_en && reg_req.rd)
            reg_rdata <= (reg_req.addr == fles_pkg::ADDR_FLASH_COMMAND)
                ? {2'b00, state_reg} : (reg_req.addr == fles_pkg::ADDR_PAGE_SELECTOR)
                ? page_selector_reg : 8'h00;
    end

    assign cpu_stall = timer_busy && !port_op_reg;
    assign port_busy = timer_busy && port_op_reg;
    assign port_status = {4'h0, port_busy, 3'b000};
    assign sector_lock = sector_lock_reg;

    // ********************************
    // checks
    // ********************************
    chk_key_order: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && state_reg == fles_pkg::ST_KEY1 && cmd_wr
        && reg_req.wdata == fles_pkg::CMD_KEY2 |=> state_reg == fles_pkg::ST_KEY2)
        else $error("second key not accepted");
    chk_bad_cmd_lock: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && state_reg == fles_pkg::ST_KEY2 && cmd_wr |=> state_reg == fles_pkg::ST_LOCKED)
        else $error("bad command did not relock");
    chk_page_match: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && state_reg == fles_pkg::ST_KEY2 && ps_wr && reg_req.wdata != first_page_reg
        |=> state_reg == fles_pkg::ST_LOCKED)
        else $error("page mismatch did not relock");
    chk_lock_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
        (sector_lock_reg & ~$past(sector_lock_reg)) == 8'h00
        || $past(state_reg) == fles_pkg::ST_SECTOR_SEL)
        else $error("sector lock changed outside selection");
    chk_lock_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
        (~sector_lock_reg & $past(sector_lock_reg)) == 8'h00)
        else $error("sector lock bit cleared");
    chk_mass_source: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && state_reg == fles_pkg::ST_UNLOCKED && cmd_wr && !reg_req.from_port
        |=> state_reg != fles_pkg::ST_MASS_ERASE)
        else $error("mass erase from cpu");
    chk_erase_relock: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && timer_done && state_reg == fles_pkg::ST_PAGE_ERASE
        |=> state_reg == fles_pkg::ST_LOCKED)
        else $error("no relock after erase");
    chk_status_upper: assert property (@(posedge ref_clk) disable iff (!resetn)
        $past(clk_en && reg_req.rd && reg_req.addr == fles_pkg::ADDR_FLASH_COMMAND)
        |-> reg_rdata[7:6] == 2'b00 && reg_rdata[5:0] == $past(state_reg))
        else $error("status readback wrong");
    chk_stall_busy: assert property (@(posedge ref_clk) disable iff (!resetn)
        cpu_stall |-> state_reg inside {fles_pkg::ST_PROGRAM, fles_pkg::ST_PAGE_ERASE,
        fles_pkg::ST_MASS_ERASE})
        else $error("stall outside operation");
    cov_unlock: cover property (@(posedge ref_clk) state_reg == fles_pkg::ST_UNLOCKED);
    cov_page_erase: cover property (@(posedge ref_clk) flash_page_erase);
    cov_mass_erase: cover property (@(posedge ref_clk) flash_mass_erase);
    cov_program: cover property (@(posedge ref_clk) flash_prog);
endmodule : fles_sequencer

/* shared/fles_pkg.sv */
// Purpose: constants and types shared by the flash lock and erase sequencer
// Assumes: 8-bit register file port, 100 MHz ref_clk
// Notes: register offsets are register-file addresses, not byte lanes
package fles_pkg;
    // ********************************
    // register map
    // ********************************
    localparam logic [7:0] ADDR_FLASH_COMMAND = 8'h01;
    localparam logic [7:0] ADDR_PAGE_SELECTOR = 8'h02;
    localparam logic [7:0] RST_PAGE_SELECTOR = 8'h00;
    localparam logic [7:0] RST_SECTOR_LOCK = 8'h00;
    localparam logic [7:0] RST_FLASH_STATE = 8'h00;
    localparam logic [15:0] RST_TIMING_DIVISOR = 16'h0000;
    // ********************************
    // command codes
    // ********************************
    localparam logic [7:0] CMD_KEY1 = 8'h73;
    localparam logic [7:0] CMD_KEY2 = 8'h8C;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
    localparam logic [7:0] CMD_SECTOR_SEL = 8'h5E;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // ********************************
    // page selector fields
    // ********************************
    localparam int INFO_AREA_BIT = 7;
    localparam logic [6:0] INFO_USER_PAGE = 7'h03;
    localparam int PAGES_PER_SECTOR_LOG2 = 4;
    localparam int MAIN_PAGE_BYTES = 512;
    localparam int INFO_PAGE_BYTES = 64;
    // ********************************
    // timing
    // ********************************
    localparam int CLK_MHZ = 100;
    localparam int PROG_TIME_US = 55;
    localparam int ERASE_TIME_MS = 10;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
    // ********************************
    // status codes
    // ********************************
    typedef enum logic [5:0] {
        ST_LOCKED = 6'b000000,
        ST_KEY1 = 6'b000001,
        ST_KEY2 = 6'b000010,
        ST_UNLOCKED = 6'b000011,
        ST_SECTOR_SEL = 6'b000100,
        ST_PROGRAM = 6'b001000,
        ST_PAGE_ERASE = 6'b010000,
        ST_MASS_ERASE = 6'b100000
    } fles_state_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic from_port;
    } fles_reg_req_t;
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic info;
    } fles_prog_req_t;
endpackage : fles_pkg

/* design/fles_timer.sv */
// Purpose: operation duration timer for program and erase
// Assumes: started with a one-cycle pulse, count fixed while running
// Notes: done is a one-cycle pulse when the count expires
module fles_timer #(
    parameter int WIDTH = 24
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [WIDTH-1:0] cycles,
    output logic busy,
    output logic done
);
    logic [WIDTH-1:0] count_reg;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count_reg <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (clk_en)
        begin
            done <= 1'b0;
            if (start)
            begin
                count_reg <= (cycles == '0) ? WIDTH'(1) : cycles;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                if (count_reg == WIDTH'(1))
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                count_reg <= count_reg - WIDTH'(1);
            end
        end
    end
endmodule : fles_timer

/* tb/fles_host.sv */
// Purpose: host model that writes and reads through the register port and byte-programs through the program port
// Assumes: requests change 1 ns after rising ref_clk and last one cycle
// Notes: released address and data lines carry the inverse of the last value
module fles_host (
    input wire logic ref_clk,
    input wire logic cpu_stall,
    input wire logic [7:0] port_status,
    input wire logic [7:0] reg_rdata,
    output fles_pkg::fles_reg_req_t reg_req,
    output fles_pkg::fles_prog_req_t prog_req
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        reg_req = '0;
        prog_req = '0;
    end
    // ********************************
    // register and program cycles
    // ********************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic port);
        @(posedge ref_clk);
        #1;
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d, from_port: port};
        @(posedge ref_clk);
        #1;
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d, from_port: port};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: reg_req.wdata, from_port: 1'b0};
        @(posedge ref_clk);
        #1;
        d = reg_rdata;
        reg_req.rd = 1'b0;
        reg_req.addr = ~a;
    endtask : rd
    task automatic prog(input logic [15:0] a, input logic [7:0] d, input logic info);
        @(posedge ref_clk);
        #1;
        prog_req = '{wr: 1'b1, addr: a, wdata: d, info: info};
        @(posedge ref_clk);
        #1;
        prog_req = '{wr: 1'b0, addr: ~a, wdata: ~d, info: info};
    endtask : prog
    task automatic cmd(input logic [7:0] c, input logic port);
        wr(fles_pkg::ADDR_FLASH_COMMAND, c, port);
    endtask : cmd
    task automatic unlock(input logic [7:0] p, input logic port);
        wr(fles_pkg::ADDR_PAGE_SELECTOR, p, port);
        cmd(fles_pkg::CMD_KEY1, port);
        cmd(fles_pkg::CMD_KEY2, port);
        wr(fles_pkg::ADDR_PAGE_SELECTOR, p, port);
    endtask : unlock
    // no new operation until the busy bit and cpu_stall read clear, bounded wait
    task automatic wait_done();
        int n;
        repeat (2) @(negedge ref_clk);
        for (n = 0; n < 60 && (port_status[3] !== 1'b0 || cpu_stall !== 1'b0); n++)
        begin
            @(negedge ref_clk);
        end
    endtask : wait_done
endmodule : fles_host

/* tb/flash_lock_erase_sequencer_tb.sv */
// Purpose: self-checking bench for the flash lock and erase sequencer
// Assumes: short program and erase counts of 8 and 20 cycles
// Notes: array strobes are counted, never taken as expected values
module flash_lock_erase_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic protect_option = 1'b0;
    logic clk_en = 1'b1;
    fles_pkg::fles_reg_req_t reg_req;
    fles_pkg::fles_prog_req_t prog_req;
    logic [7:0] reg_rdata, port_status, sector_lock, flash_wdata, d;
    logic cpu_stall, port_busy, flash_prog, flash_page_erase, flash_mass_erase, flash_info;
    logic [15:0] flash_addr;
    int fails = 0;
    int samples_checked = 0;
    int n_prog = 0;
    int n_pe = 0;
    int n_me = 0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        if (flash_prog === 1'b1) n_prog++;
        if (flash_page_erase === 1'b1) n_pe++;
        if (flash_mass_erase === 1'b1) n_me++;
    end
    fles_sequencer #(.SECTORS(8), .PROG_CYCLES(8), .ERASE_CYCLES(20)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .prog_req(prog_req), .protect_option(protect_option),
        .timing_divisor(16'h00C8), .cpu_stall(cpu_stall), .port_busy(port_busy),
        .port_status(port_status), .flash_prog(flash_prog),
        .flash_page_erase(flash_page_erase), .flash_mass_erase(flash_mass_erase),
        .flash_info(flash_info), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .sector_lock(sector_lock));
    fles_host u_host (.ref_clk(ref_clk), .cpu_stall(cpu_stall), .port_status(port_status),
        .reg_rdata(reg_rdata), .reg_req(reg_req), .prog_req(prog_req));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic st(input logic [7:0] exp);
        u_host.rd(fles_pkg::ADDR_FLASH_COMMAND, d);
        chk(16'(d), 16'(exp));
    endtask : st
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    // run is under 2000 cycles; the limit leaves a wide margin
    initial
    begin
        #100000;
        fails++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        summarize();
    end
    initial
    begin
        repeat (20) @(posedge ref_clk);
        #1 resetn = 1'b1;
        st(fles_pkg::RST_FLASH_STATE);
        chk(16'(sector_lock), 16'(fles_pkg::RST_SECTOR_LOCK));
        @(posedge ref_clk);
        #1 clk_en = 1'b0;
        u_host.cmd(fles_pkg::CMD_KEY1, 1'b0);
        @(posedge ref_clk);
        #1 clk_en = 1'b1;
        st(fles_pkg::RST_FLASH_STATE);
        u_host.prog(16'h0A10, 8'h55, 1'b0);
        repeat (3) @(negedge ref_clk);
        chk(16'(n_prog), 16'h0000);
        u_host.wr(fles_pkg::ADDR_PAGE_SELECTOR, 8'h05, 1'b0);
        u_host.cmd(fles_pkg::CMD_KEY1, 1'b0);
        st(8'h01);
        u_host.cmd(fles_pkg::CMD_KEY2, 1'b0);
        st(8'h02);
        u_host.wr(fles_pkg::ADDR_PAGE_SELECTOR, 8'h05, 1'b0);
        st(8'h03);
        u_host.rd(fles_pkg::ADDR_PAGE_SELECTOR, d);
        chk(16'(d), 16'h0005);
        u_host.prog(16'h0A10, 8'h55, 1'b0);
        st(8'h08);
        chk(16'(cpu_stall), 16'h0001);
        chk(flash_addr, 16'h0A10);
        chk(16'(flash_wdata), 16'h0055);
        u_host.wait_done();
        st(8'h03);
        u_host.prog(16'h0C00, 8'h11, 1'b0);
        u_host.prog(16'h0BFF, 8'h22, 1'b0);
        u_host.wait_done();
        chk(16'(n_prog), 16'h0002);
        u_host.cmd(8'h00, 1'b0);
        st(8'h00);
        $display("test unlock and program done");
        u_host.wr(fles_pkg::ADDR_PAGE_SELECTOR, 8'h05, 1'b0);
        u_host.cmd(fles_pkg::CMD_KEY1, 1'b0);
        u_host.cmd(fles_pkg::CMD_KEY2, 1'b0);
        u_host.wr(fles_pkg::ADDR_PAGE_SELECTOR, 8'h06, 1'b0);
        st(8'h00);
        u_host.wr(fles_pkg::ADDR_PAGE_SELECTOR, 8'h05, 1'b0);
        u_host.cmd(fles_pkg::CMD_KEY1, 1'b0);
        u_host.cmd(fles_pkg::CMD_PAGE_ERASE, 1'b0);
        st(8'h00);
        u_host.unlock(8'h05, 1'b0);
        u_host.cmd(fles_pkg::CMD_PAGE_ERASE, 1'b0);
        st(8'h10);
        chk(16'(cpu_stall), 16'h0001);
        u_host.wait_done();
        st(8'h00);
        chk(16'(n_pe), 16'h0001);
        u_host.unlock(8'h05, 1'b0);
        u_host.cmd(fles_pkg::CMD_MASS_ERASE, 1'b0);
        u_host.wait_done();
        chk(16'(n_me), 16'h0000);
        $display("test relock and page erase done");
        @(posedge ref_clk);
        #1 protect_option = 1'b1;
        u_host.unlock(8'h83, 1'b1);
        u_host.cmd(fles_pkg::CMD_PAGE_ERASE, 1'b1);
        u_host.wait_done();
        chk(16'(n_pe), 16'h0001);
        u_host.unlock(8'h05, 1'b1);
        u_host.cmd(fles_pkg::CMD_MASS_ERASE, 1'b1);
        repeat (2) @(negedge ref_clk);
        chk(16'(port_status), 16'h0008);
        chk(16'(port_busy), 16'h0001);
        chk(16'(cpu_stall), 16'h0000);
        st(8'h20);
        u_host.wait_done();
        chk(16'(n_me), 16'h0001);
        st(8'h00);
        u_host.unlock(8'h83, 1'b1);
        u_host.cmd(fles_pkg::CMD_PAGE_ERASE, 1'b1);
        u_host.wait_done();
        chk(16'(n_pe), 16'h0002);
        chk(16'(flash_info), 16'h0001);
        $display("test port erases done");
        u_host.unlock(8'h05, 1'b0);
        u_host.cmd(fles_pkg::CMD_SECTOR_SEL, 1'b0);
        st(8'h04);
        u_host.wr(fles_pkg::ADDR_PAGE_SELECTOR, 8'h01, 1'b0);
        u_host.rd(fles_pkg::ADDR_PAGE_SELECTOR, d);
        chk(16'(d), 16'h0005);
        u_host.wr(fles_pkg::ADDR_PAGE_SELECTOR, 8'h00, 1'b0);
        chk(16'(sector_lock), 16'h0001);
        u_host.cmd(8'h00, 1'b0);
        u_host.unlock(8'h05, 1'b0);
        u_host.cmd(fles_pkg::CMD_SECTOR_SEL, 1'b0);
        u_host.wr(fles_pkg::ADDR_PAGE_SELECTOR, 8'h00, 1'b0);
        chk(16'(sector_lock), 16'h0001);
        u_host.cmd(8'h00, 1'b0);
        u_host.unlock(8'h05, 1'b0);
        u_host.cmd(fles_pkg::CMD_PAGE_ERASE, 1'b0);
        u_host.wait_done();
        chk(16'(n_pe), 16'h0002);
        u_host.cmd(8'h00, 1'b0);
        u_host.unlock(8'h15, 1'b0);
        u_host.cmd(fles_pkg::CMD_PAGE_ERASE, 1'b0);
        u_host.wait_done();
        chk(16'(n_pe), 16'h0003);
        $display("test sector lock done");
        summarize();
    end
endmodule : flash_lock_erase_sequencer_tb
